// ===== include/meru_pkg.sv
// Constants and types for the mode-entry register update block
package meru_pkg;

	// Operating modes reported by the mode state machine
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_STANDBY,
		MODE_NORMAL,
		MODE_SLEEP,
		MODE_RESET,
		MODE_OVERLOAD,
		MODE_FAILSAFE
	} meru_mode_t;

	// Register byte addresses
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_WDOG = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_LIVE = 8'h0c;
	localparam logic [7:0] ADDR_NVCFG = 8'h10;
	localparam logic [7:0] ADDR_SWCTRL = 8'h14;
	localparam logic [7:0] ADDR_LINCFG = 8'h18;
	localparam logic [7:0] ADDR_THRESH = 8'h1c;
	localparam logic [7:0] ADDR_IDMASK = 8'h20;
	localparam logic [7:0] ADDR_IOFLAG = 8'h24;
	localparam logic [7:0] ADDR_IOMASK = 8'h28;
	localparam logic [7:0] ADDR_MSFLAG = 8'h2c;
	localparam logic [7:0] ADDR_MSMASK = 8'h30;

	// Operating-mode control encodings
	localparam logic [2:0] MC_STANDBY = 3'h4;
	localparam logic [2:0] MC_NORMAL = 3'h7;
	localparam logic [2:0] MC_SLEEP = 3'h1;

	// Field widths and reset values
	localparam int MC_W = 3;
	localparam int WDOG_W = 4;
	localparam logic [3:0] WDOG_DEF = 4'h4;
	localparam int RCC_W = 2;
	localparam logic [1:0] RCC_DEF = 2'h0;
	localparam int IDM_W = 29;
	localparam logic [1:0] PIN_OFF_STATE = 2'h3;

	// Control register bit positions
	localparam int CTRL_RCC_LO = 0;
	localparam int CTRL_LHC = 2;
	localparam int CTRL_NMS = 3;
	localparam int CTRL_PN_DATA_MASK_EN = 4;

	// Misc flag register bit positions (mask uses the same layout)
	localparam int MS_LINWAKE_LO = 0;
	localparam int MS_OTW = 2;
	localparam int MS_OVSD = 3;
	localparam int MS_POR = 4;
	localparam int MS_PN_CONFIG_VALID = 5;
	localparam int MS_PNERR = 6;
	localparam int MS_W = 7;

	// Live status register bit positions
	localparam int LIVE_WLS_LO = 16;
	localparam int LIVE_OVERTEMP_WARN_STATUS = 24;
	localparam int LIVE_NVPS = 25;

	// LIN config register positions
	localparam int LIN_MODE_LO = 4;
	localparam int LIN_LOCK_LO = 8;

	// Threshold register: short-circuit field starts here
	localparam int THR_SC_LO = 16;

endpackage : meru_pkg

// ===== verilog/meru_core.sv
// Mode-entry register update with register port and interrupt
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - Mode control field set per entered mode, kept on Overload
// - Watchdog period defaults on Reset, Overload and failsafe entries
// - Reset counter counts Reset entries, clears failsafe
// - Normal status cleared on Normal entry
// - Pin state reads 11 in Off
// - Failsafe sets wake interrupt enables
// - Failsafe clears listed interrupt flags
// - Failsafe clears fault interrupt enables
// - Switch control cleared on Overload, failsafe
// - Data-mask enable set at failsafe entry
// - Wake identifier mask cleared in failsafe
// - Nonvolatile config bits always from store
// - Overtemp and wake level read 0 in Off
// - Programmed status always live
// - LIN and threshold fields only reset
// - Writes during mode change are discarded
module meru_core #(
	parameter int NIO = 8,
	parameter int NLIN = 2,
	parameter int NSFC = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic modeEnter,
	input wire meru_pkg::meru_mode_t modeNext,
	input wire logic accessActive,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [2*NIO-1:0] pinStateIn,
	input wire logic [NIO-1:0] wakeLevelIn,
	input wire logic otwIn,
	input wire logic vbatAboveUvIn,
	input wire logic nvProgIn,
	input wire logic [NIO-1:0] highsideNv,
	input wire logic [NIO-1:0] lowsideNv,
	input wire logic [NSFC-1:0] startupNv,
	input wire logic [NIO-1:0] riseEvt,
	input wire logic [NIO-1:0] fallEvt,
	input wire logic [NIO-1:0] openLoadEvt,
	input wire logic [NIO-1:0] shortEvt,
	input wire logic [meru_pkg::MS_W-1:0] miscEvt,
	output logic [meru_pkg::MC_W-1:0] opModeCtrl,
	output logic [meru_pkg::WDOG_W-1:0] wdogPeriodSel,
	output logic limpHomeCtrl,
	output logic [2*NIO-1:0] pinSwitchCtrl,
	output logic irq
);
	import meru_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Synchronisers and mode tracking

	logic [2*NIO-1:0] pinMeta_r, pinSync_r;
	logic [NIO-1:0] wlsMeta_r, wlsSync_r;
	logic [2:0] liveMeta_r, liveSync_r;
	meru_mode_t curMode_r;
	logic discard_r;
	logic wrOk, fsEnter, rstEnter, ovlEnter;
	logic [NIO-1:0] hsNv_r, lsNv_r;
	logic [NSFC-1:0] sfNv_r;

	// Two-flop synchronisers for pin and comparator levels
	always_ff @(posedge clk) begin
		pinMeta_r <= pinStateIn;
		pinSync_r <= pinMeta_r;
		wlsMeta_r <= wakeLevelIn;
		wlsSync_r <= wlsMeta_r;
		liveMeta_r <= {nvProgIn, vbatAboveUvIn, otwIn};
		liveSync_r <= liveMeta_r;
	end

	// nonvolatile copies
	// Registered so read data come from flops; store is static anyway
	always_ff @(posedge clk) begin
		hsNv_r <= highsideNv;
		lsNv_r <= lowsideNv;
		sfNv_r <= startupNv;
	end

	// Power-on reset is the Off mode
	always_ff @(posedge clk) begin
		if (rst) begin
			curMode_r <= MODE_OFF;
		end else if (modeEnter) begin
			curMode_r <= modeNext;
		end
	end

	assign fsEnter = modeEnter && (modeNext == MODE_FAILSAFE);
	assign rstEnter = modeEnter && (modeNext == MODE_RESET);
	assign ovlEnter = modeEnter && (modeNext == MODE_OVERLOAD);

	// access discard
	// A frame caught by a mode change takes no writes until it ends
	always_ff @(posedge clk) begin
		if (rst) begin
			discard_r <= 1'b0;
		end else if (modeEnter && accessActive) begin
			discard_r <= 1'b1;
		end else if (!accessActive) begin
			discard_r <= 1'b0;
		end
	end

	assign wrOk = wr && !modeEnter && !discard_r;

	////////////////////////////////////////////////////////////////////
	// Control fields

	logic [RCC_W-1:0] rcc_r;
	logic nms_r, pn_data_mask_en_r;
	logic [IDM_W-1:0] idMask_r;
	logic [4*NLIN-1:0] linCfg_r;
	logic [NLIN-1:0] linLock_r;
	logic [2*NIO-1:0] olThr_r, scThr_r;

	// mode control
	// Overload leaves the field as it was
	always_ff @(posedge clk) begin
		if (rst) begin
			opModeCtrl <= MC_STANDBY;
		end else if (modeEnter) begin
			case (modeNext)
				MODE_STANDBY, MODE_RESET, MODE_OFF: begin
					opModeCtrl <= MC_STANDBY;
				end
				MODE_NORMAL: begin
					opModeCtrl <= MC_NORMAL;
				end
				MODE_SLEEP, MODE_FAILSAFE: begin
					opModeCtrl <= MC_SLEEP;
				end
				default: begin
					opModeCtrl <= opModeCtrl;
				end
			endcase
		end else if (wrOk && addr == ADDR_MODE) begin
			opModeCtrl <= wdata[MC_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wdogPeriodSel <= WDOG_DEF;
		end else if (rstEnter || ovlEnter || fsEnter) begin
			wdogPeriodSel <= WDOG_DEF;
		end else if (wrOk && addr == ADDR_WDOG) begin
			wdogPeriodSel <= wdata[WDOG_W-1:0];
		end
	end

	// reset counter
	// Wraps after three; counts only with battery above threshold
	always_ff @(posedge clk) begin
		if (rst) begin
			rcc_r <= RCC_DEF;
		end else if (fsEnter) begin
			rcc_r <= RCC_DEF;
		end else if (rstEnter) begin
			if (liveSync_r[1]) begin
				rcc_r <= rcc_r + RCC_W'(1);
			end
		end else if (wrOk && addr == ADDR_CTRL) begin
			rcc_r <= wdata[CTRL_RCC_LO +: RCC_W];
		end
	end

	// limp home, normal status, data mask enable
	always_ff @(posedge clk) begin
		if (rst) begin
			limpHomeCtrl <= 1'b0;
			nms_r <= 1'b1;
			pn_data_mask_en_r <= 1'b1;
		end else if (modeEnter) begin
			if (ovlEnter || fsEnter) begin
				limpHomeCtrl <= 1'b1;
			end
			if (modeNext == MODE_NORMAL) begin
				nms_r <= 1'b0;
			end
			if (fsEnter) begin
				pn_data_mask_en_r <= 1'b1;
			end
		end else if (wrOk && addr == ADDR_CTRL) begin
			limpHomeCtrl <= wdata[CTRL_LHC];
			nms_r <= wdata[CTRL_NMS];
			pn_data_mask_en_r <= wdata[CTRL_PN_DATA_MASK_EN];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || ovlEnter || fsEnter) begin
			pinSwitchCtrl <= '0;
		end else if (wrOk && addr == ADDR_SWCTRL) begin
			pinSwitchCtrl <= wdata[2*NIO-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst || fsEnter) begin
			idMask_r <= '0;
		end else if (wrOk && addr == ADDR_IDMASK) begin
			idMask_r <= wdata[IDM_W-1:0];
		end
	end

	// reset-only fields
	// No mode entry touches these, failsafe included
	always_ff @(posedge clk) begin
		if (rst) begin
			linCfg_r <= '0;
			linLock_r <= '0;
			olThr_r <= '0;
			scThr_r <= '0;
		end else if (wrOk && addr == ADDR_LINCFG) begin
			linCfg_r <= wdata[4*NLIN-1:0];
			linLock_r <= wdata[LIN_LOCK_LO +: NLIN];
		end else if (wrOk && addr == ADDR_THRESH) begin
			olThr_r <= wdata[2*NIO-1:0];
			scThr_r <= wdata[THR_SC_LO +: 2*NIO];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt flags and enables

	logic [4*NIO-1:0] ioFlag_r, ioMask_r, ioEvt, ioW1c;
	logic [MS_W-1:0] msFlag_r, msMask_r, msW1c;

	assign ioEvt = {shortEvt, openLoadEvt, fallEvt, riseEvt};
	assign ioW1c = (wrOk && addr == ADDR_IOFLAG) ? wdata[4*NIO-1:0] : '0;
	assign msW1c = (wrOk && addr == ADDR_MSFLAG) ? wdata[MS_W-1:0] : '0;

	// failsafe flag clear
	// Event beats software clear; failsafe entry beats both
	always_ff @(posedge clk) begin
		if (rst || fsEnter) begin
			ioFlag_r <= '0;
			msFlag_r <= '0;
		end else begin
			ioFlag_r <= (ioFlag_r & ~ioW1c) | ioEvt;
			msFlag_r <= (msFlag_r & ~msW1c) | miscEvt;
		end
	end

	// wake enables set, fault enables cleared
	always_ff @(posedge clk) begin
		if (rst) begin
			ioMask_r <= '0;
			msMask_r <= '0;
		end else if (fsEnter) begin
			ioMask_r <= {{(2*NIO){1'b0}}, {(2*NIO){1'b1}}};
			msMask_r <= '0;
			msMask_r[MS_LINWAKE_LO +: NLIN] <= '1;
		end else if (wrOk && addr == ADDR_IOMASK) begin
			ioMask_r <= wdata[4*NIO-1:0];
		end else if (wrOk && addr == ADDR_MSMASK) begin
			msMask_r <= wdata[MS_W-1:0];
		end
	end

	// Level interrupt while any enabled flag stands
	assign irq = |(ioFlag_r & ioMask_r) || |(msFlag_r & msMask_r);

	////////////////////////////////////////////////////////////////////
	// Read path

	logic offNow;
	logic [31:0] rdNxt;
	assign offNow = (curMode_r == MODE_OFF);

	// pin state, Off masking, live programmed bit
	always_comb begin
		rdNxt = '0;
		case (addr)
			ADDR_MODE: rdNxt[MC_W-1:0] = opModeCtrl;
			ADDR_WDOG: rdNxt[WDOG_W-1:0] = wdogPeriodSel;
			ADDR_CTRL: begin
				rdNxt[CTRL_RCC_LO +: RCC_W] = rcc_r;
				rdNxt[CTRL_LHC] = limpHomeCtrl;
				rdNxt[CTRL_NMS] = nms_r;
				rdNxt[CTRL_PN_DATA_MASK_EN] = pn_data_mask_en_r;
			end
			ADDR_LIVE: begin
				rdNxt[2*NIO-1:0] = offNow ? {NIO{PIN_OFF_STATE}} : pinSync_r;
				rdNxt[LIVE_WLS_LO +: NIO] = offNow ? '0 : wlsSync_r;
				rdNxt[LIVE_OVERTEMP_WARN_STATUS] = offNow ? 1'b0 : liveSync_r[0];
				rdNxt[LIVE_NVPS] = liveSync_r[2];
			end
			ADDR_NVCFG: rdNxt = 32'({sfNv_r, lsNv_r, hsNv_r});
			ADDR_SWCTRL: rdNxt[2*NIO-1:0] = pinSwitchCtrl;
			ADDR_LINCFG: begin
				rdNxt[4*NLIN-1:0] = linCfg_r;
				rdNxt[LIN_LOCK_LO +: NLIN] = linLock_r;
			end
			ADDR_THRESH: rdNxt = 32'({scThr_r, olThr_r});
			ADDR_IDMASK: rdNxt[IDM_W-1:0] = idMask_r;
			ADDR_IOFLAG: rdNxt[4*NIO-1:0] = ioFlag_r;
			ADDR_IOMASK: rdNxt[4*NIO-1:0] = ioMask_r;
			ADDR_MSFLAG: rdNxt[MS_W-1:0] = msFlag_r;
			ADDR_MSMASK: rdNxt[MS_W-1:0] = msMask_r;
			default: rdNxt = '0;
		endcase
	end

	// Read data stand one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (rst || !rd) begin
			rdata <= '0;
		end else begin
			rdata <= rdNxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	mode_normal_code_a: assert property (
		modeEnter && modeNext == MODE_NORMAL |=> opModeCtrl == MC_NORMAL)
		else $error("mode control not normal code after entry");

	mode_overload_keep_a: assert property (
		ovlEnter |=> opModeCtrl == $past(opModeCtrl))
		else $error("mode control changed on overload entry");

	wdog_default_a: assert property (
		rstEnter || ovlEnter || fsEnter |=> wdogPeriodSel == WDOG_DEF)
		else $error("watchdog period not defaulted");

	rcc_increment_a: assert property (
		rstEnter && liveSync_r[1] |=> rcc_r == $past(rcc_r) + RCC_W'(1))
		else $error("reset counter did not step");

	rcc_hold_low_a: assert property (
		rstEnter && !liveSync_r[1] |=> $stable(rcc_r))
		else $error("reset counter moved at low battery");

	limp_set_a: assert property (
		ovlEnter || fsEnter |=> limpHomeCtrl)
		else $error("limp home not set");

	nms_clear_a: assert property (
		modeEnter && modeNext == MODE_NORMAL |=> !nms_r)
		else $error("normal status not cleared");

	pin_off_read_a: assert property (
		rd && addr == ADDR_LIVE && offNow
		|=> rdata[2*NIO-1:0] == {NIO{PIN_OFF_STATE}}
		&& rdata[LIVE_OVERTEMP_WARN_STATUS] == 1'b0)
		else $error("off mode live read wrong");

	fs_enables_a: assert property (
		fsEnter |=> &ioMask_r[2*NIO-1:0] && ioMask_r[4*NIO-1:2*NIO] == '0
		&& &msMask_r[MS_LINWAKE_LO +: NLIN] && !msMask_r[MS_OTW])
		else $error("failsafe enables wrong");

	fs_flags_a: assert property (
		fsEnter |=> ioFlag_r == '0 && msFlag_r == '0 && !irq)
		else $error("failsafe flags not cleared");

	switch_clear_a: assert property (
		ovlEnter || fsEnter |=> pinSwitchCtrl == '0)
		else $error("switch control not cleared");

	lin_keep_a: assert property (
		modeEnter && !wr |=> $stable(linCfg_r) && $stable(olThr_r))
		else $error("reset-only field moved on mode change");

	discard_write_a: assert property (
		modeEnter && accessActive ##1 wr && addr == ADDR_WDOG
		&& !modeEnter && accessActive |=> $stable(wdogPeriodSel))
		else $error("write inside broken frame took effect");

	flag_set_wins_a: assert property (
		!fsEnter && riseEvt[0] && wrOk && addr == ADDR_IOFLAG
		|=> ioFlag_r[0])
		else $error("event lost against software clear");

	irq_level_a: assert property (
		(ioFlag_r[0] && ioMask_r[0]) |-> irq)
		else $error("interrupt not raised");

	failsafe_c: cover property (fsEnter ##[1:20] rstEnter);
	reset_twice_c: cover property (rstEnter ##[1:20] rstEnter);
	discard_c: cover property (modeEnter && accessActive ##1 wr);
	irq_c: cover property (!irq ##1 irq);

endmodule : meru_core

// ===== testbench/testbench.sv
// Self-checking bench for the mode-entry register update block
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errTotal++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module testbench;
	import meru_pkg::*;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic modeEnter = 1'h0;
	logic accessActive = 1'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	meru_mode_t modeNext = MODE_OFF;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic [15:0] pinStateIn = 16'h1234;
	logic [7:0] wakeLevelIn = 8'h5a;
	logic [7:0] highsideNv = 8'hc3;
	logic [7:0] lowsideNv = 8'h3c;
	logic [2:0] startupNv = 3'h5;
	logic [7:0] riseEvt = 8'h00, fallEvt = 8'h00;
	logic [7:0] openLoadEvt = 8'h00, shortEvt = 8'h00;
	logic [6:0] miscEvt = 7'h00;
	logic otwIn = 1'h1, vbatAboveUvIn = 1'h1, nvProgIn = 1'h1;
	logic [2:0] opModeCtrl;
	logic [3:0] wdogPeriodSel;
	logic limpHomeCtrl, irq;
	logic [15:0] pinSwitchCtrl;
	int errTotal = 0;
	int checksDone = 0;
	int cyc = 0;

	meru_core dut (.clk(clk), .rst(rst), .modeEnter(modeEnter),
		.modeNext(modeNext), .accessActive(accessActive), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pinStateIn(pinStateIn), .wakeLevelIn(wakeLevelIn), .otwIn(otwIn),
		.vbatAboveUvIn(vbatAboveUvIn), .nvProgIn(nvProgIn),
		.highsideNv(highsideNv), .lowsideNv(lowsideNv),
		.startupNv(startupNv), .riseEvt(riseEvt), .fallEvt(fallEvt),
		.openLoadEvt(openLoadEvt), .shortEvt(shortEvt), .miscEvt(miscEvt),
		.opModeCtrl(opModeCtrl), .wdogPeriodSel(wdogPeriodSel),
		.limpHomeCtrl(limpHomeCtrl), .pinSwitchCtrl(pinSwitchCtrl),
		.irq(irq));

	// 10 MHz clock
	always #50 clk = ~clk;

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			errTotal++;
			summarize();
		end
	end

	task automatic summarize;
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	// Bus and stimulus helpers; each ends just after the edge it used
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
	endtask : wreg

	task automatic rreg(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m = 32'hffff_ffff);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		`CHK(rdata & m, e)
	endtask : rreg

	task automatic enter(input meru_mode_t m);
		@(posedge clk);
		modeNext <= m;
		modeEnter <= 1'h1;
		@(posedge clk);
		modeEnter <= 1'h0;
		#1;
	endtask : enter

	task automatic pulse(input logic [31:0] io, input logic [6:0] ms);
		@(posedge clk);
		{shortEvt, openLoadEvt, fallEvt, riseEvt} <= io;
		miscEvt <= ms;
		@(posedge clk);
		{shortEvt, openLoadEvt, fallEvt, riseEvt} <= 32'h0000_0000;
		miscEvt <= 7'h00;
		#1;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////
	// Power-on values, Off-mode live view, unmapped read
	task automatic t_reset;
		`CHK(opModeCtrl, 3'h4)
		`CHK(wdogPeriodSel, 4'h4)
		`CHK(limpHomeCtrl, 1'h0)
		`CHK(pinSwitchCtrl, 16'h0000)
		rreg(ADDR_CTRL, 32'h0000_0018);
		rreg(ADDR_IDMASK, 32'h0000_0000);
		rreg(ADDR_LINCFG, 32'h0000_0000);
		rreg(ADDR_THRESH, 32'h0000_0000);
		rreg(ADDR_IOMASK, 32'h0000_0000);
		rreg(ADDR_MSFLAG, 32'h0000_0000);
		rreg(ADDR_LIVE, 32'h0200_ffff);
		rreg(ADDR_NVCFG, 32'h0005_3cc3);
		rreg(8'h40, 32'h0000_0000);
	endtask : t_reset

	// Mode control codes, normal flag, live status and Off re-entry
	task automatic t_modes;
		meru_mode_t ms[3] = '{MODE_STANDBY, MODE_NORMAL, MODE_SLEEP};
		logic [2:0] mc[3] = '{3'h4, 3'h7, 3'h1};
		wreg(ADDR_WDOG, 32'h0000_0009);
		foreach (ms[i]) begin
			enter(ms[i]);
			`CHK(opModeCtrl, mc[i])
			rreg(ADDR_MODE, 32'(mc[i]));
			`CHK(wdogPeriodSel, 4'h9)
			rreg(ADDR_CTRL, {28'h000_0000, ms[i] != MODE_NORMAL, 3'h0},
				32'h0000_0008);
			wreg(ADDR_CTRL, 32'h0000_0018);
		end
		rreg(ADDR_LIVE, 32'h035a_1234);
		@(posedge clk);
		pinStateIn <= 16'h8421;
		otwIn <= 1'h0;
		repeat (4) @(posedge clk);
		rreg(ADDR_LIVE, 32'h025a_8421);
		enter(MODE_OFF);
		`CHK(opModeCtrl, 3'h4)
		@(posedge clk);
		highsideNv <= 8'h0f;
		nvProgIn <= 1'h0;
		repeat (4) @(posedge clk);
		rreg(ADDR_LIVE, 32'h0000_ffff);
		rreg(ADDR_NVCFG, 32'h0005_3c0f);
	endtask : t_modes

	// Reset entries count only while the battery is above threshold
	task automatic t_rcc;
		enter(MODE_STANDBY);
		wreg(ADDR_WDOG, 32'h0000_000b);
		enter(MODE_RESET);
		`CHK(wdogPeriodSel, 4'h4)
		`CHK(opModeCtrl, 3'h4)
		enter(MODE_RESET);
		rreg(ADDR_CTRL, 32'h0000_0002, 32'h0000_0003);
		@(posedge clk);
		vbatAboveUvIn <= 1'h0;
		repeat (4) @(posedge clk);
		enter(MODE_RESET);
		rreg(ADDR_CTRL, 32'h0000_0002, 32'h0000_0003);
	endtask : t_rcc

	// Overload forces switches, watchdog and limp-home once
	task automatic t_overload;
		wreg(ADDR_SWCTRL, 32'h0000_5555);
		wreg(ADDR_WDOG, 32'h0000_0009);
		`CHK(pinSwitchCtrl, 16'h5555)
		enter(MODE_OVERLOAD);
		`CHK(pinSwitchCtrl, 16'h0000)
		`CHK(wdogPeriodSel, 4'h4)
		`CHK(limpHomeCtrl, 1'h1)
		`CHK(opModeCtrl, 3'h4)
		wreg(ADDR_SWCTRL, 32'h0000_00aa);
		`CHK(pinSwitchCtrl, 16'h00aa)
		enter(MODE_STANDBY);
		`CHK(limpHomeCtrl, 1'h1)
		`CHK(pinSwitchCtrl, 16'h00aa)
	endtask : t_overload

	// Fail-safe entry with every flag pending and enables inverted
	task automatic t_failsafe;
		wreg(ADDR_IOMASK, 32'hffff_0000);
		wreg(ADDR_MSMASK, 32'h0000_0004);
		wreg(ADDR_IDMASK, 32'hffff_ffff);
		wreg(ADDR_LINCFG, 32'h0000_03ff);
		wreg(ADDR_THRESH, 32'hffff_ffff);
		wreg(ADDR_WDOG, 32'h0000_0009);
		wreg(ADDR_SWCTRL, 32'h0000_ffff);
		wreg(ADDR_CTRL, 32'h0000_000a);
		pulse(32'hffff_ffff, 7'h7f);
		rreg(ADDR_MSFLAG, 32'h0000_007f);
		`CHK(irq, 1'h1)
		enter(MODE_FAILSAFE);
		`CHK(opModeCtrl, 3'h1)
		`CHK(wdogPeriodSel, 4'h4)
		`CHK(limpHomeCtrl, 1'h1)
		`CHK(pinSwitchCtrl, 16'h0000)
		`CHK(irq, 1'h0)
		rreg(ADDR_CTRL, 32'h0000_001c);
		rreg(ADDR_IOFLAG, 32'h0000_0000);
		rreg(ADDR_MSFLAG, 32'h0000_0000);
		rreg(ADDR_IOMASK, 32'h0000_ffff);
		rreg(ADDR_MSMASK, 32'h0000_0003, 32'h0000_0007);
		rreg(ADDR_IDMASK, 32'h0000_0000, 32'h1fff_ffff);
		rreg(ADDR_LINCFG, 32'h0000_03ff);
		rreg(ADDR_THRESH, 32'hffff_ffff);
		wreg(ADDR_IOMASK, 32'h0000_0000);
		rreg(ADDR_IOMASK, 32'h0000_0000);
	endtask : t_failsafe

	// Writes that collide with a mode change are dropped
	task automatic t_discard;
		wreg(ADDR_WDOG, 32'h0000_0003);
		@(posedge clk);
		addr <= ADDR_WDOG;
		wdata <= 32'h0000_000c;
		wr <= 1'h1;
		modeNext <= MODE_SLEEP;
		modeEnter <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		modeEnter <= 1'h0;
		#1;
		`CHK(wdogPeriodSel, 4'h3)
		`CHK(opModeCtrl, 3'h1)
		@(posedge clk);
		accessActive <= 1'h1;
		modeNext <= MODE_STANDBY;
		modeEnter <= 1'h1;
		// Write follows the entry with no gap, inside the same frame
		@(posedge clk);
		modeEnter <= 1'h0;
		addr <= ADDR_WDOG;
		wdata <= 32'h0000_000c;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
		#1;
		`CHK(wdogPeriodSel, 4'h3)
		`CHK(opModeCtrl, 3'h4)
		@(posedge clk);
		accessActive <= 1'h0;
		wreg(ADDR_WDOG, 32'h0000_000c);
		`CHK(wdogPeriodSel, 4'hc)
	endtask : t_discard

	// Sticky flags, masking and write-one-to-clear on the interrupt
	task automatic t_irq;
		wreg(ADDR_IOMASK, 32'h0000_0001);
		pulse(32'h0000_0002, 7'h00);
		`CHK(irq, 1'h0)
		rreg(ADDR_IOFLAG, 32'h0000_0002);
		pulse(32'h0000_0001, 7'h00);
		`CHK(irq, 1'h1)
		wreg(ADDR_IOFLAG, 32'h0000_0001);
		`CHK(irq, 1'h0)
		rreg(ADDR_IOFLAG, 32'h0000_0002);
		wreg(ADDR_MSMASK, 32'h0000_0004);
		pulse(32'h0000_0000, 7'h04);
		`CHK(irq, 1'h1)
		wreg(ADDR_MSFLAG, 32'h0000_0004);
		`CHK(irq, 1'h0)
		// Event and software clear in one cycle: the event wins
		@(posedge clk);
		riseEvt <= 8'h01;
		addr <= ADDR_IOFLAG;
		wdata <= 32'h0000_0001;
		wr <= 1'h1;
		@(posedge clk);
		riseEvt <= 8'h00;
		wr <= 1'h0;
		#1;
		`CHK(irq, 1'h1)
		rreg(ADDR_IOFLAG, 32'h0000_0003);
	endtask : t_irq

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		#1;
		t_reset();
		t_modes();
		t_rcc();
		t_overload();
		t_failsafe();
		t_discard();
		t_irq();
		summarize();
	end
endmodule : testbench
